// File: rtl/tx_drive_pkg.sv
// Constants and types shared by the antenna driver selection logic.
package tx_drive_pkg;
  // ---------------------------------------------------------------
  // Conductance code widths and field positions
  // ---------------------------------------------------------------
  localparam int PMOS_W      = 6;
  localparam int NMOS_W      = 4;
  localparam int NMOS_CW_LSB = 4;  // Steady-wave field sits in the upper nibble.
  localparam int NMOS_MD_LSB = 0;  // Modulation field sits in the lower nibble.

  // ---------------------------------------------------------------
  // Route select field positions and codes
  // ---------------------------------------------------------------
  localparam int AUX_ROUTE_LSB = 0;
  localparam int DRV_SEL_LSB   = 4;
  localparam int RX_SRC_LSB    = 6;
  localparam int INV_MOD_BIT   = 3;
  localparam logic [3:0] AUX_LOW      = 4'h0;
  localparam logic [3:0] AUX_HIGH     = 4'h1;
  localparam logic [3:0] AUX_ENVELOPE = 4'h2;
  localparam logic [3:0] AUX_TX_NRZ   = 4'h3;
  localparam logic [3:0] AUX_MILLER   = 4'h4;
  localparam logic [3:0] AUX_RX_CODED = 4'h5;
  localparam logic [1:0] DRV_OFF      = 2'h0;
  localparam logic [1:0] DRV_INTERNAL = 2'h1;
  localparam logic [1:0] DRV_AUX_IN   = 2'h2;
  localparam logic [1:0] DRV_HIGH     = 2'h3;
  localparam logic [1:0] RX_ANALOG    = 2'h0;
  localparam logic [1:0] RX_AUX_IN    = 2'h1;
  localparam logic [1:0] RX_LOOPBACK  = 2'h2;

  // ---------------------------------------------------------------
  // Receive framing and reset values
  // ---------------------------------------------------------------
  localparam logic [3:0]  BIT_PARITY   = 4'h8;   // Ninth bit of a byte is parity.
  localparam logic [15:0] CRC_PRESET   = 16'h6363;
  localparam logic [15:0] CRC_POLY_REF = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE  = 16'h0000;

  // One driver's output: pin level and both conductance codes.
  typedef struct packed {
    logic              level;
    logic [PMOS_W-1:0] pmos_conductance_sel;
    logic [NMOS_W-1:0] nmos_conductance_sel;
  } drive_s;

  localparam drive_s DRIVE_RST = '0;
endpackage

// File: rtl/antenna_driver_signal_select.sv
// Antenna driver level and conductance selection with serial data switch.
// Function
// - Carrier is the oscillator clock divided by two.
// - Each pin carries the carrier modulated by the envelope.
// - With carrier disabled the pin is held low on the steady codes.
// - Plain mode: carrier out; envelope 0 modulation codes, 1 steady codes.
// - PMOS steady code comes from the PMOS steady register.
// - NMOS steady code comes from the steady nibble of NMOS register.
// - Modulation codes come from the PMOS register and NMOS modulation nibble.
// - Invert-while-on bit inverts the carrier outside full-depth ASK; code choice unchanged.
// - Full-depth ASK: envelope 0 forces low, 1 carrier or inverted; the second driver steady-wave bit overrides it.
// - Second driver steady-wave bit forces steady codes always.
// - Both drivers use the same conductance registers.
// - Framing and route registers set the driver envelope source and polarity.
// - Serial switch routes internal coded signals to auxiliary pins.
// - Receive engine frames bytes, checks odd parity and CRC.
// - Aux route code 100b sends the Miller signal out.
// - Receive source 01 takes the auxiliary input pin.
module antenna_driver_signal_select
  import tx_drive_pkg::*;
(
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // Driver pin control bits
  input  wire logic                 carrier_enable_first,
  input  wire logic                 carrier_enable_second,
  input  wire logic                 full_depth_ask_force,
  input  wire logic                 invert_on_first,
  input  wire logic                 invert_off_first,
  input  wire logic                 second_driver_steady_wave,
  input  wire logic                 invert_on_second,
  input  wire logic                 invert_off_second,
  // Conductance and route registers
  input  wire logic [PMOS_W-1:0]    pmos_steady_conductance_reg,
  input  wire logic [PMOS_W-1:0]    pmos_modulation_conductance_reg,
  input  wire logic [7:0]           nmos_conductance_reg,
  input  wire logic [7:0]           transmit_framing_reg,
  input  wire logic [7:0]           transmit_route_select_reg,
  input  wire logic [7:0]           receive_route_select_reg,
  // Internal coder signals
  input  wire logic                 envelope,
  input  wire logic                 tx_nrz,
  input  wire logic                 miller_tx,
  input  wire logic                 rx_analog,
  // Receive bit stream
  input  wire logic                 rx_frame_start,
  input  wire logic                 rx_frame_end,
  input  wire logic                 rx_bit_valid,
  input  wire logic                 rx_bit,
  // Auxiliary pins, antenna drive words and receiver input
  input  wire logic                 aux_serial_in,
  output tx_drive_pkg::drive_s      antenna_drive_first,
  output tx_drive_pkg::drive_s      antenna_drive_second,
  output logic                      aux_serial_out,
  output logic                      rx_signal,
  // Receive results
  output logic [7:0]                rx_byte,
  output logic                      rx_byte_valid,
  output logic                      parity_error,
  output logic                      crc_error
);
  import tx_drive_pkg::*;

  // ---------------------------------------------------------------
  // Carrier and synchroniser
  // ---------------------------------------------------------------
  logic        carrier_ff;
  logic        aux_in_meta_ff;
  logic        aux_in_ff;
  logic        env_eff;
  logic [3:0]  aux_route;
  logic [1:0]  drv_sel;
  logic [1:0]  rx_src;
  drive_s      nxt_first;
  drive_s      nxt_second;

  // The carrier toggles every oscillator edge, so it runs at half rate.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      carrier_ff <= 1'b0;
    end else begin
      carrier_ff <= ~carrier_ff;
    end
  end

  // The auxiliary input comes from a pin, so it passes two flops first.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aux_in_meta_ff <= 1'b0;
      aux_in_ff      <= 1'b0;
    end else begin
      aux_in_meta_ff <= aux_serial_in;
      aux_in_ff      <= aux_in_meta_ff;
    end
  end

  // ---------------------------------------------------------------
  // Envelope source and polarity
  // ---------------------------------------------------------------
  assign aux_route = transmit_route_select_reg[AUX_ROUTE_LSB +: 4];
  assign drv_sel   = transmit_route_select_reg[DRV_SEL_LSB +: 2];
  assign rx_src    = receive_route_select_reg[RX_SRC_LSB +: 2];

  // The driver select picks who modulates the carrier; off means steady carrier.
  always_comb begin
    case (drv_sel)
      DRV_INTERNAL: env_eff = envelope ^ transmit_framing_reg[INV_MOD_BIT];
      DRV_AUX_IN:   env_eff = aux_in_ff ^ transmit_framing_reg[INV_MOD_BIT];
      default:      env_eff = 1'b1;
    endcase
  end

  // ---------------------------------------------------------------
  // Driver selection
  // ---------------------------------------------------------------
  // One function serves both pins, so both draw the same registers.
  // The carrier argument is the value the carrier takes on this edge,
  // which keeps the registered pin in phase with carrier_ff.
  function automatic drive_s drive_calc(input logic en, input logic ask,
                                        input logic inv_on, input logic inv_off,
                                        input logic cw, input logic env,
                                        input logic car);
    drive_s d;
    logic   steady;
    d      = DRIVE_RST;
    steady = 1'b1;
    if (!en) begin
      d.level = 1'b0;
    end else if (cw) begin
      d.level = car ^ inv_on;
    end else if (ask) begin
      d.level = env & (car ^ inv_off);
      steady  = env;
    end else begin
      d.level = car ^ inv_on;
      steady  = env;
    end
    d.pmos_conductance_sel = steady ? pmos_steady_conductance_reg
                                    : pmos_modulation_conductance_reg;
    d.nmos_conductance_sel = steady ? nmos_conductance_reg[NMOS_CW_LSB +: NMOS_W]
                                    : nmos_conductance_reg[NMOS_MD_LSB +: NMOS_W];
    return d;
  endfunction

  assign nxt_first  = drive_calc(carrier_enable_first, full_depth_ask_force,
                                 invert_on_first, invert_off_first, 1'b0,
                                 env_eff, ~carrier_ff);
  assign nxt_second = drive_calc(carrier_enable_second, full_depth_ask_force,
                                 invert_on_second, invert_off_second,
                                 second_driver_steady_wave, env_eff, ~carrier_ff);

  // Registering the selection hides decode glitches from the analog drivers.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      antenna_drive_first  <= DRIVE_RST;
      antenna_drive_second <= DRIVE_RST;
    end else begin
      antenna_drive_first  <= nxt_first;
      antenna_drive_second <= nxt_second;
    end
  end

  // ---------------------------------------------------------------
  // Serial data switch
  // ---------------------------------------------------------------
  // Unused route codes drive low so an unconfigured pin stays quiet.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aux_serial_out <= 1'b0;
    end else begin
      case (aux_route)
        AUX_HIGH:     aux_serial_out <= 1'b1;
        AUX_ENVELOPE: aux_serial_out <= env_eff;
        AUX_TX_NRZ:   aux_serial_out <= tx_nrz;
        AUX_MILLER:   aux_serial_out <= miller_tx;
        AUX_RX_CODED: aux_serial_out <= rx_analog;
        default:      aux_serial_out <= 1'b0;
      endcase
    end
  end

  // Receiver input source select.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_signal <= 1'b0;
    end else begin
      case (rx_src)
        RX_ANALOG:   rx_signal <= rx_analog;
        RX_AUX_IN:   rx_signal <= aux_in_ff;
        RX_LOOPBACK: rx_signal <= miller_tx;
        default:     rx_signal <= 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Receive framing, parity and CRC
  // ---------------------------------------------------------------
  logic [3:0]  bit_cnt_ff;
  logic [7:0]  shift_ff;
  logic [15:0] crc_ff;
  logic        parity_bad;

  assign parity_bad = rx_bit_valid && (bit_cnt_ff == BIT_PARITY)
                      && !(^{shift_ff, rx_bit});

  // Data bits arrive LSB first; the ninth bit closes the byte.
  always_ff @(posedge ref_clk) begin
    if (rst || rx_frame_start) begin
      bit_cnt_ff <= 4'h0;
      shift_ff   <= 8'h00;
      crc_ff     <= CRC_PRESET;
    end else if (rx_bit_valid) begin
      if (bit_cnt_ff == BIT_PARITY) begin
        bit_cnt_ff <= 4'h0;
      end else begin
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
        shift_ff   <= {rx_bit, shift_ff[7:1]};
        crc_ff     <= {1'b0, crc_ff[15:1]}
                      ^ ((crc_ff[0] ^ rx_bit) ? CRC_POLY_REF : 16'h0000);
      end
    end
  end

  // Completed byte strobe.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_byte       <= 8'h00;
      rx_byte_valid <= 1'b0;
    end else begin
      rx_byte_valid <= rx_bit_valid && (bit_cnt_ff == BIT_PARITY) && !rx_frame_start;
      if (rx_bit_valid && (bit_cnt_ff == BIT_PARITY)) begin
        rx_byte <= shift_ff;
      end
    end
  end

  // Error flags clear at frame start; a parity detection in that cycle wins, a CRC check at frame end does not.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      parity_error <= 1'b0;
      crc_error    <= 1'b0;
    end else begin
      if (parity_bad) begin
        parity_error <= 1'b1;
      end else if (rx_frame_start) begin
        parity_error <= 1'b0;
      end
      if (rx_frame_end && !rx_frame_start) begin
        crc_error <= (crc_ff != CRC_RESIDUE);
      end else if (rx_frame_start) begin
        crc_error <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_plain_carrier: assert property (
    (carrier_enable_first && !full_depth_ask_force) |=>
      antenna_drive_first.level == (carrier_ff ^ $past(invert_on_first)))
    else $error("first pin does not follow carrier");
  a_carrier_toggles: assert property (
    (carrier_enable_first && !full_depth_ask_force && !invert_on_first)[*3] |=>
      antenna_drive_first.level != $past(antenna_drive_first.level))
    else $error("carrier not at half clock rate");
  a_disabled_low: assert property (
    !carrier_enable_second |=> !antenna_drive_second.level
      && antenna_drive_second.pmos_conductance_sel == $past(pmos_steady_conductance_reg))
    else $error("disabled pin not low with steady codes");
  a_env_mod_codes: assert property (
    (carrier_enable_first && !env_eff) |=>
      antenna_drive_first.pmos_conductance_sel == $past(pmos_modulation_conductance_reg)
      && antenna_drive_first.nmos_conductance_sel == $past(nmos_conductance_reg[3:0]))
    else $error("envelope low did not select modulation codes");
  a_env_cw_codes: assert property (
    (carrier_enable_first && env_eff) |=>
      antenna_drive_first.nmos_conductance_sel == $past(nmos_conductance_reg[7:4]))
    else $error("envelope high did not select steady nmos code");
  a_ask_forced_low: assert property (
    (carrier_enable_first && full_depth_ask_force && !env_eff) |=>
      !antenna_drive_first.level)
    else $error("full-depth ask did not pull pin low");
  a_steady_second: assert property (
    (carrier_enable_second && second_driver_steady_wave) |=>
      antenna_drive_second.pmos_conductance_sel == $past(pmos_steady_conductance_reg))
    else $error("second driver steady-wave ignored");
  a_shared_codes: assert property (
    (carrier_enable_first && carrier_enable_second && !second_driver_steady_wave) |=>
      antenna_drive_first.pmos_conductance_sel == antenna_drive_second.pmos_conductance_sel)
    else $error("drivers use different codes");
  a_aux_miller: assert property (
    (aux_route == AUX_MILLER) |=> aux_serial_out == $past(miller_tx))
    else $error("miller signal not on aux output");
  a_rx_aux_src: assert property (
    (rx_src == RX_AUX_IN) |=> rx_signal == $past(aux_in_ff))
    else $error("receiver not fed from aux input");
  a_parity_sticky: assert property (
    parity_bad |=> parity_error)
    else $error("parity error lost");

  c_ask_pulse: cover property (full_depth_ask_force && carrier_enable_first && !env_eff);
  c_inverted: cover property (carrier_enable_second && invert_on_second);
  c_byte_done: cover property (rx_byte_valid ##[1:20] rx_byte_valid);
endmodule

// File: testbench/antenna_field_model.sv
// Behavioural model of the analog driver arrays fed by the two drive pins.
module antenna_field_model
  import tx_drive_pkg::*;
(
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // Drive words from the selection logic
  input  wire tx_drive_pkg::drive_s drv_a,
  input  wire tx_drive_pkg::drive_s drv_b,
  // Observed field
  output logic                      field_on
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] last_ff;

  // A pin held at one level radiates nothing, so only a toggle counts as field.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      last_ff  <= 2'h0;
      field_on <= 1'b0;
    end else begin
      last_ff  <= {drv_b.level, drv_a.level};
      field_on <= (drv_a.level != last_ff[0]) || (drv_b.level != last_ff[1]);
    end
  end
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the antenna driver selection logic.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tx_drive_pkg::*;
  // --------------------
  // Signals
  // --------------------
  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  logic              carrier_enable_first, carrier_enable_second, full_depth_ask_force;
  logic              invert_on_first, invert_off_first, second_driver_steady_wave;
  logic              invert_on_second, invert_off_second;
  logic [PMOS_W-1:0] pmos_steady_conductance_reg, pmos_modulation_conductance_reg;
  logic [7:0]        nmos_conductance_reg, transmit_framing_reg;
  logic [7:0]        transmit_route_select_reg, receive_route_select_reg;
  logic              envelope, tx_nrz, miller_tx, rx_analog, aux_serial_in;
  logic              rx_frame_start, rx_frame_end, rx_bit_valid, rx_bit;
  drive_s            antenna_drive_first, antenna_drive_second, e1, e2;
  logic              aux_serial_out, rx_signal, rx_byte_valid, parity_error, crc_error;
  logic [7:0]        rx_byte;
  logic              field_on, car_ff, ee;
  logic [15:0]       crc;
  int                n_mismatch = 0;
  int                cmp_count = 0;

  always #25 ref_clk = ~ref_clk;
  // Own carrier phase: cleared in reset, toggles on every edge after it.
  always @(posedge ref_clk) car_ff <= rst ? 1'b0 : ~car_ff;

  antenna_driver_signal_select i_antenna_driver_signal_select (
    .ref_clk, .rst, .carrier_enable_first, .carrier_enable_second, .full_depth_ask_force,
    .invert_on_first, .invert_off_first, .second_driver_steady_wave, .invert_on_second,
    .invert_off_second, .pmos_steady_conductance_reg, .pmos_modulation_conductance_reg,
    .nmos_conductance_reg, .transmit_framing_reg, .transmit_route_select_reg,
    .receive_route_select_reg, .envelope, .tx_nrz, .miller_tx, .rx_analog,
    .rx_frame_start, .rx_frame_end, .rx_bit_valid, .rx_bit, .aux_serial_in,
    .antenna_drive_first, .antenna_drive_second, .aux_serial_out, .rx_signal,
    .rx_byte, .rx_byte_valid, .parity_error, .crc_error);

  antenna_field_model i_antenna_field_model (
    .ref_clk, .rst, .drv_a(antenna_drive_first), .drv_b(antenna_drive_second), .field_on);
  // --------------------
  // Helpers
  // --------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Expected pin word; a disabled pin is held low on steady codes.
  function automatic drive_s exp_drv(input logic en, ask, ion, ioff, sw, env, car);
    drive_s d;
    logic   st;
    st = !en || sw || env;
    d.level = !en ? 1'b0 : (sw || !ask) ? car ^ ion : env ? car ^ ioff : 1'b0;
    d.pmos_conductance_sel = st ? pmos_steady_conductance_reg : pmos_modulation_conductance_reg;
    d.nmos_conductance_sel = st ? nmos_conductance_reg[7:4] : nmos_conductance_reg[3:0];
    return d;
  endfunction

  // Nine bits LSB first with odd parity; flip spoils the parity bit.
  task automatic send_byte(input logic [7:0] b, input logic flip);
    for (int k = 0; k < 9; k++) begin
      @(posedge ref_clk);
      #1;
      rx_bit_valid = 1'b1;
      rx_bit = (k < 8) ? b[k] : ~^b ^ flip;
      if (k < 8) begin
        crc = (crc >> 1) ^ ((crc[0] ^ b[k]) ? CRC_POLY_REF : 16'h0000);
      end
    end
    @(posedge ref_clk);
    #1;
    rx_bit_valid = 1'b0;
    for (int w = 0; w < 3 && rx_byte_valid !== 1'b1; w++) begin
      @(posedge ref_clk);
      #2;
    end
    check(rx_byte_valid, 1'b1);
    check(rx_byte, b);
    check(parity_error, flip);
  endtask

  // A faulty frame has a bad parity bit and no check bytes, so both flags rise.
  task automatic frame(input logic fault);
    logic [15:0] c;
    @(posedge ref_clk);
    #1;
    rx_frame_start = 1'b1;
    @(posedge ref_clk);
    #1;
    rx_frame_start = 1'b0;
    crc = CRC_PRESET;
    send_byte(8'h93, 1'b0);
    send_byte(8'h5C, fault);
    c = crc;
    if (!fault) begin
      send_byte(c[7:0], 1'b0);
      send_byte(c[15:8], 1'b0);
    end
    @(posedge ref_clk);
    #1;
    rx_frame_end = 1'b1;
    @(posedge ref_clk);
    #1;
    rx_frame_end = 1'b0;
    @(posedge ref_clk);
    #2;
    check(crc_error, fault);
    check(parity_error, fault);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // --------------------
  // Tests
  // --------------------
  // Whole run is under 4000 cycles; the limit leaves ample margin.
  initial begin
    #(50 * 8000);
    n_mismatch++;
    finish_test();
  end

  initial begin
    {carrier_enable_first, carrier_enable_second, full_depth_ask_force, invert_on_first,
     invert_off_first, second_driver_steady_wave, invert_on_second, invert_off_second,
     envelope} = 9'h000;
    {tx_nrz, miller_tx, rx_analog, aux_serial_in} = 4'h0;
    {rx_frame_start, rx_frame_end, rx_bit_valid, rx_bit} = 4'h0;
    {pmos_steady_conductance_reg, pmos_modulation_conductance_reg} = 12'h000;
    {nmos_conductance_reg, transmit_framing_reg} = 16'h0000;
    transmit_route_select_reg = 8'h10;
    receive_route_select_reg = 8'h00;
    repeat (6) @(posedge ref_clk);
    #1;
    check(16'(antenna_drive_first), 16'(DRIVE_RST));
    rst = 1'b0;
    // Every control combination, checked on two edges so the carrier must toggle.
    for (int i = 0; i < 512; i++) begin
      @(posedge ref_clk);
      #1;
      {carrier_enable_first, carrier_enable_second, full_depth_ask_force, invert_on_first,
       invert_off_first, second_driver_steady_wave, invert_on_second, invert_off_second,
       envelope} = 9'(i);
      pmos_steady_conductance_reg = 6'(i);
      pmos_modulation_conductance_reg = ~6'(i);
      nmos_conductance_reg = {4'(i), ~4'(i)};
      repeat (2) begin
        @(posedge ref_clk);
        #2;
        e1 = exp_drv(carrier_enable_first, full_depth_ask_force, invert_on_first,
                     invert_off_first, 1'b0, envelope, car_ff);
        e2 = exp_drv(carrier_enable_second, full_depth_ask_force, invert_on_second,
                     invert_off_second, second_driver_steady_wave, envelope, car_ff);
        check(16'(antenna_drive_first), 16'(e1));
        check(16'(antenna_drive_second), 16'(e2));
      end
    end
    // Envelope source and polarity; the pin input passes a two-flop synchroniser.
    {carrier_enable_first, carrier_enable_second, full_depth_ask_force, invert_on_first,
     invert_off_first, second_driver_steady_wave, invert_on_second, invert_off_second,
     envelope} = 9'h100;
    for (int j = 0; j < 16; j++) begin
      @(posedge ref_clk);
      #1;
      transmit_route_select_reg = {2'h0, 2'(j >> 2), 4'h0};
      transmit_framing_reg = {4'h0, j[1], 3'h0};
      aux_serial_in = j[0];
      repeat (4) @(posedge ref_clk);
      #2;
      ee = (j[3:2] == 2'h1) ? j[1] : (j[3:2] == 2'h2) ? j[0] ^ j[1] : 1'b1;
      e1 = exp_drv(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, ee, car_ff);
      check(16'(antenna_drive_first), 16'(e1));
    end
    // Auxiliary output routes and receive sources, each seen at both levels.
    transmit_framing_reg = 8'h00;
    for (int k = 0; k < 16; k++) begin
      @(posedge ref_clk);
      #1;
      {envelope, tx_nrz, miller_tx, rx_analog, aux_serial_in} = {5{k[3]}};
      transmit_route_select_reg = 8'h10 | 8'(k[2:0]);
      receive_route_select_reg = {2'(k), 6'h00};
      repeat (4) @(posedge ref_clk);
      #2;
      check(aux_serial_out, (k[2:0] == 3'h1) || (k[2:0] inside {[3'h2:3'h5]} && k[3]));
      check(rx_signal, (k[1:0] != 2'h3) && k[3]);
    end
    frame(1'b1);
    frame(1'b0);
    // Full-depth keying with a low envelope must silence the field.
    @(posedge ref_clk);
    #1;
    {full_depth_ask_force, envelope} = 2'h2;
    repeat (3) @(posedge ref_clk);
    #2;
    check(field_on, 1'b0);
    envelope = 1'b1;
    repeat (3) @(posedge ref_clk);
    #2;
    check(field_on, 1'b1);
    finish_test();
  end
endmodule
